// ---- shared/ebs_pkg.sv ----
// External bus cycle sequencer: shared constants, field layouts and state codes.
// Assumes one system clock for the request side and a bus clock for the pins.
package ebs_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CS_N = 4;
  localparam int CSEL_W = 2;
  localparam int CFG_W = 16;
  localparam int BE_W = 2;
  // ----------------------------------------------------------------
  // Timing configuration word, one per chip select
  // ----------------------------------------------------------------
  localparam int CFG_AB = 0;
  localparam int CFG_ABX = 1;
  localparam int CFG_C = 3;
  localparam int CFG_D = 5;
  localparam int CFG_E = 6;
  localparam int CFG_F = 11;
  localparam int CFG_RDY_EN = 13;
  localparam int CFG_RDY_POL = 14;
  localparam int CFG_RDY_ASYNC = 15;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Request word layout in the buffer
  // ----------------------------------------------------------------
  localparam int REQ_BE = 0;
  localparam int REQ_DAT = 2;
  localparam int REQ_ADR = 18;
  localparam int REQ_CS = 42;
  localparam int REQ_WR = 44;
  localparam int REQ_W = 45;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PH_W = 6;
  localparam int SUB_W = 4;
  localparam int SYS_MAX_MHZ = 80;
  localparam int MIN_TRANS_PS = 12500;
  localparam int BUS_CLK_PS = 12500;
  localparam int TCS_RAW = (MIN_TRANS_PS + BUS_CLK_PS - 1) / BUS_CLK_PS;
  localparam int TCS_CYC = (TCS_RAW < 1) ? 1 : TCS_RAW;
  localparam logic [SUB_W-1:0] SUB_LOAD = SUB_W'(TCS_CYC - 1);
  typedef enum logic [2:0] {
    EBS_IDLE = 3'h0,
    EBS_AB = 3'h1,
    EBS_C = 3'h3,
    EBS_D = 3'h2,
    EBS_E = 3'h6,
    EBS_RDY = 3'h7,
    EBS_F = 3'h5
  } ebs_state_t;
endpackage

// ---- core/ebs_sync2.sv ----
// Two-flop synchroniser for levels and quasi-static words.
// Assumes multi-bit inputs change only while the far side is idle.
module ebs_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [W-1:0] d, // Source-domain level
  output logic [W-1:0] q // Synchronised level
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ---- core/ebs_buf2.sv ----
// Small request FIFO with valid/ready on both sides.
// Assumes a single clock; depth must be a power of two.
module ebs_buf2 #(
  parameter int W = 8,
  parameter int D = 2
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic in_valid, // Writer offers a word
  output logic in_ready, // Space available
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Reader takes the word
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wp_r - rp_r) != (AW+1)'(D);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// ---- core/ebs_seq.sv ----
// External bus cycle sequencer: request side on mclk, pin side on bus_clk.
// Assumes config and mode inputs change only while busy is low.
module ebs_seq (
  input wire logic mclk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic bus_clk, // Bus clock driving the pins
  input wire logic req_valid, // Request offered
  output logic req_ready, // Request accepted
  input wire logic req_write, // 1 write, 0 read
  input wire logic [ebs_pkg::CSEL_W-1:0] req_cs, // Chip select number
  input wire logic [ebs_pkg::ADDR_W-1:0] req_addr, // Bus address
  input wire logic [ebs_pkg::DATA_W-1:0] req_wdata, // Write data
  input wire logic [ebs_pkg::BE_W-1:0] req_be, // Byte enables
  output logic rsp_valid, // Cycle finished, pulse
  output logic [ebs_pkg::DATA_W-1:0] rsp_rdata, // Read data
  output logic busy, // Requests outstanding
  input wire logic [ebs_pkg::CS_N*ebs_pkg::CFG_W-1:0] chip_select_timing_config, // Per-CS
  input wire logic mux_mode, // 1 multiplexed bus
  input wire logic ref_clk_en, // Enable reference clock pin
  output logic bus_reference_clock, // Reference clock out
  output logic [ebs_pkg::ADDR_W-1:0] separate_address_lines, // Address pins
  output logic [ebs_pkg::DATA_W-1:0] shared_addr_data_o, // Data/address out
  input wire logic [ebs_pkg::DATA_W-1:0] shared_addr_data_i, // Data/address in
  output logic shared_addr_data_oe, // Drive data/address pins
  output logic [ebs_pkg::CS_N-1:0] chip_sel_n, // Chip selects, low active
  output logic upper_byte_select_n, // Upper byte enable, low active
  output logic addr_latch_en, // Address latch enable
  output logic read_strobe_n, // Read strobe, low active
  output logic write_strobe_n, // Write strobe, low active
  input wire logic ready_pin // Ready handshake pin
);
  localparam int CFGB_W = ebs_pkg::CS_N * ebs_pkg::CFG_W + 3;
  localparam int AB_LO = 1;
  localparam int AB_HI = 2;

  // ----------------------------------------------------------------
  // Request side: buffer and hand-off
  // ----------------------------------------------------------------
  logic [ebs_pkg::REQ_W-1:0] buf_data;
  logic buf_valid;
  logic buf_take;
  logic [ebs_pkg::REQ_W-1:0] hold_r;
  logic req_tgl_r;
  logic pend_r;
  logic done_seen_r;
  logic done_m;
  logic rsp_valid_r;
  logic [ebs_pkg::DATA_W-1:0] rsp_rdata_r;
  logic done_tgl_r;
  logic [ebs_pkg::DATA_W-1:0] rdata_b_r;

  wire [ebs_pkg::REQ_W-1:0] req_word = {req_write, req_cs, req_addr, req_wdata, req_be};
  ebs_buf2 #(.W(ebs_pkg::REQ_W), .D(2)) u_buf (
    .clk(mclk),
    .nrst(nrst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req_word),
    .out_valid(buf_valid),
    .out_ready(buf_take),
    .out_data(buf_data)
  );
  // One request in flight; the buffer absorbs the next two while the bus works
  assign buf_take = buf_valid && !pend_r;
  wire done_evt = done_m != done_seen_r;

  ebs_sync2 #(.W(1)) u_done_sync (
    .clk(mclk),
    .nrst(nrst),
    .d(done_tgl_r),
    .q(done_m)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= '0;
      req_tgl_r <= 1'b0;
      pend_r <= 1'b0;
      done_seen_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
    end else begin
      done_seen_r <= done_m;
      rsp_valid_r <= done_evt;
      if (buf_take) begin
        hold_r <= buf_data;
        req_tgl_r <= ~req_tgl_r;
        pend_r <= 1'b1;
      end else if (done_evt) begin
        pend_r <= 1'b0;
      end
      // Read data is stable: the bus side wrote it no later than the edge that toggles done
      if (done_evt) begin
        rsp_rdata_r <= rdata_b_r;
      end
    end
  end
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;
  assign busy = pend_r || buf_valid;

  // ----------------------------------------------------------------
  // Crossing into the bus domain
  // ----------------------------------------------------------------
  logic [CFGB_W-1:0] cfgb;
  logic rdy_s2;
  ebs_sync2 #(.W(CFGB_W)) u_cfg_sync (
    .clk(bus_clk),
    .nrst(nrst),
    .d({chip_select_timing_config, mux_mode, ref_clk_en, req_tgl_r}),
    .q(cfgb)
  );
  ebs_sync2 #(.W(1)) u_rdy_sync (
    .clk(bus_clk),
    .nrst(nrst),
    .d(ready_pin),
    .q(rdy_s2)
  );
  wire [ebs_pkg::CS_N*ebs_pkg::CFG_W-1:0] cfg_all = cfgb[CFGB_W-1:3];
  wire mux_b = cfgb[2];
  wire refen_b = cfgb[1];
  wire req_tgl_b = cfgb[0];

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  ebs_pkg::ebs_state_t st_r;
  ebs_pkg::ebs_state_t st_nxt;
  logic req_seen_r;
  logic [ebs_pkg::PH_W-1:0] la_r, lc_r, ld_r, le_r, lf_r;
  logic [ebs_pkg::PH_W-1:0] unit_r;
  logic [ebs_pkg::SUB_W-1:0] sub_r;
  logic wr_r, mux_r, rdy_en_r, rdy_pol_r, rdy_as_r, rdy_s3_r, refen_r;
  logic [ebs_pkg::ADDR_W-1:0] adr_r;
  logic [ebs_pkg::DATA_W-1:0] wd_r;
  logic [ebs_pkg::BE_W-1:0] be_r;
  logic [ebs_pkg::CSEL_W-1:0] cs_r, last_cs_r;
  logic [ebs_pkg::CS_N-1:0] cs_n_r;
  logic ale_r, rd_n_r, wr_n_r, ad_oe_r, ubs_n_r;
  logic [ebs_pkg::DATA_W-1:0] ad_o_r;

  function automatic logic [ebs_pkg::PH_W-1:0] len_of(input ebs_pkg::ebs_state_t s,
      input logic [ebs_pkg::PH_W-1:0] a, input logic [ebs_pkg::PH_W-1:0] c,
      input logic [ebs_pkg::PH_W-1:0] d, input logic [ebs_pkg::PH_W-1:0] e,
      input logic [ebs_pkg::PH_W-1:0] f);
    unique case (s)
      ebs_pkg::EBS_AB: len_of = a;
      ebs_pkg::EBS_C: len_of = c;
      ebs_pkg::EBS_D: len_of = d;
      ebs_pkg::EBS_E: len_of = e;
      ebs_pkg::EBS_F: len_of = f;
      default: len_of = 6'h01;
    endcase
  endfunction

  wire start = (st_r == ebs_pkg::EBS_IDLE) && (req_tgl_b != req_seen_r);
  wire [ebs_pkg::CSEL_W-1:0] cs_new = hold_r[ebs_pkg::REQ_CS +: ebs_pkg::CSEL_W];
  wire [ebs_pkg::CFG_W-1:0] cfg = cfg_all[cs_new*ebs_pkg::CFG_W +: ebs_pkg::CFG_W];
  wire [ebs_pkg::PH_W-1:0] ab_base = cfg[ebs_pkg::CFG_AB] ? 6'(AB_HI) : 6'(AB_LO);
  wire [ebs_pkg::PH_W-1:0] ab_ext = (cs_new != last_cs_r) ? 6'(cfg[ebs_pkg::CFG_ABX +: 2])
                                                         : 6'h00;
  wire [ebs_pkg::PH_W-1:0] la_new = ab_base + ab_ext;
  wire [ebs_pkg::PH_W-1:0] lc_new = 6'(cfg[ebs_pkg::CFG_C +: 2]);
  wire [ebs_pkg::PH_W-1:0] ld_new = 6'(cfg[ebs_pkg::CFG_D]);
  wire [ebs_pkg::PH_W-1:0] le_new = 6'(cfg[ebs_pkg::CFG_E +: 5]) + 6'h01;
  wire [ebs_pkg::PH_W-1:0] lf_new = 6'(cfg[ebs_pkg::CFG_F +: 2]);
  wire [ebs_pkg::PH_W-1:0] lc_u = start ? lc_new : lc_r;
  wire [ebs_pkg::PH_W-1:0] ld_u = start ? ld_new : ld_r;
  wire [ebs_pkg::PH_W-1:0] lf_u = start ? lf_new : lf_r;

  // Async mode reads one flop later, costing the extra waitstate
  wire rdy_lvl = rdy_as_r ? rdy_s3_r : rdy_s2;
  wire rdy_act = rdy_lvl == rdy_pol_r;
  // A unit is TCS_CYC bus clocks so pin edges stay 12.5 ns apart
  wire unit_end = (sub_r == '0) && (unit_r == 6'h01);
  wire after_d = ld_r != '0;
  ebs_pkg::ebs_state_t to_tail;
  assign to_tail = (lf_r != '0) ? ebs_pkg::EBS_F : ebs_pkg::EBS_IDLE;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ebs_pkg::EBS_IDLE: if (start) st_nxt = ebs_pkg::EBS_AB;
      ebs_pkg::EBS_AB: if (unit_end) begin
        st_nxt = (lc_r != '0) ? ebs_pkg::EBS_C : after_d ? ebs_pkg::EBS_D : ebs_pkg::EBS_E;
      end
      ebs_pkg::EBS_C: if (unit_end) begin
        st_nxt = after_d ? ebs_pkg::EBS_D : ebs_pkg::EBS_E;
      end
      ebs_pkg::EBS_D: if (unit_end) st_nxt = ebs_pkg::EBS_E;
      ebs_pkg::EBS_E: if (unit_end) st_nxt = rdy_en_r ? ebs_pkg::EBS_RDY : to_tail;
      ebs_pkg::EBS_RDY: if ((sub_r == '0) && rdy_act) st_nxt = to_tail;
      ebs_pkg::EBS_F: if (unit_end) st_nxt = ebs_pkg::EBS_IDLE;
      default: st_nxt = ebs_pkg::EBS_IDLE;
    endcase
  end

  // Pin values for the coming state, registered below
  wire strobe_ph = (st_nxt == ebs_pkg::EBS_E) || (st_nxt == ebs_pkg::EBS_RDY);
  wire in_ab = st_nxt == ebs_pkg::EBS_AB;
  wire wr_u = start ? hold_r[ebs_pkg::REQ_WR] : wr_r;
  wire mux_u = start ? mux_b : mux_r;
  wire data_ph = strobe_ph || (st_nxt == ebs_pkg::EBS_D) || (st_nxt == ebs_pkg::EBS_F);
  wire [ebs_pkg::ADDR_W-1:0] adr_u = start ? hold_r[ebs_pkg::REQ_ADR +: ebs_pkg::ADDR_W]
                                           : adr_r;
  wire [ebs_pkg::DATA_W-1:0] wd_u = start ? hold_r[ebs_pkg::REQ_DAT +: ebs_pkg::DATA_W] : wd_r;
  wire oe_nxt = (mux_u && in_ab) || (wr_u && data_ph);
  wire [ebs_pkg::DATA_W-1:0] ado_nxt = (mux_u && in_ab) ? adr_u[ebs_pkg::DATA_W-1:0] : wd_u;
  wire [ebs_pkg::CSEL_W-1:0] cs_u = start ? cs_new : cs_r;
  wire [ebs_pkg::CS_N-1:0] csn_nxt = (st_nxt == ebs_pkg::EBS_IDLE) ? '1
                                     : ~(ebs_pkg::CS_N'(1) << cs_u);
  wire strobe_end = (st_r == ebs_pkg::EBS_E || st_r == ebs_pkg::EBS_RDY) && !strobe_ph;

  always_ff @(posedge bus_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ebs_pkg::EBS_IDLE;
      unit_r <= 6'h01;
      sub_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        sub_r <= ebs_pkg::SUB_LOAD;
        unit_r <= len_of(st_nxt, start ? la_new : la_r, lc_u, ld_u,
                         start ? le_new : le_r, lf_u);
      end else if (sub_r == '0) begin
        sub_r <= ebs_pkg::SUB_LOAD;
        if (unit_r > 6'h01) unit_r <= unit_r - 6'h01;
      end else begin
        sub_r <= sub_r - 1'b1;
      end
    end
  end

  always_ff @(posedge bus_clk or negedge nrst) begin
    if (!nrst) begin
      req_seen_r <= 1'b0;
      {la_r, lc_r, ld_r, le_r, lf_r} <= '0;
      {wr_r, mux_r, rdy_en_r, rdy_pol_r, rdy_as_r} <= '0;
      adr_r <= '0;
      wd_r <= '0;
      be_r <= '0;
      cs_r <= '0;
      last_cs_r <= '0;
    end else if (start) begin
      req_seen_r <= req_tgl_b;
      {la_r, lc_r, ld_r, le_r, lf_r} <= {la_new, lc_new, ld_new, le_new, lf_new};
      wr_r <= hold_r[ebs_pkg::REQ_WR];
      mux_r <= mux_b;
      rdy_en_r <= cfg[ebs_pkg::CFG_RDY_EN];
      rdy_pol_r <= cfg[ebs_pkg::CFG_RDY_POL];
      rdy_as_r <= cfg[ebs_pkg::CFG_RDY_ASYNC];
      adr_r <= adr_u;
      wd_r <= wd_u;
      be_r <= hold_r[ebs_pkg::REQ_BE +: ebs_pkg::BE_W];
      cs_r <= cs_new;
      last_cs_r <= cs_new;
    end
  end

  always_ff @(posedge bus_clk or negedge nrst) begin
    if (!nrst) begin
      cs_n_r <= '1;
      {ale_r, ad_oe_r} <= 2'h0;
      {rd_n_r, wr_n_r, ubs_n_r} <= 3'h7;
      ad_o_r <= '0;
      rdata_b_r <= '0;
      done_tgl_r <= 1'b0;
      rdy_s3_r <= 1'b0;
      refen_r <= 1'b0;
    end else begin
      rdy_s3_r <= rdy_s2;
      refen_r <= refen_b;
      cs_n_r <= csn_nxt;
      ale_r <= mux_u && in_ab;
      rd_n_r <= !(strobe_ph && !wr_u);
      wr_n_r <= !(strobe_ph && wr_u);
      ubs_n_r <= !(start ? hold_r[ebs_pkg::REQ_BE + 1] : be_r[1]);
      ad_oe_r <= oe_nxt;
      ad_o_r <= ado_nxt;
      // Same edge that ends the strobe; later address moves are ignored
      if (strobe_end && !wr_r) rdata_b_r <= shared_addr_data_i;
      if (st_r != ebs_pkg::EBS_IDLE && st_nxt == ebs_pkg::EBS_IDLE) begin
        done_tgl_r <= ~done_tgl_r;
      end
    end
  end

  // Fast clock pin carries the bus clock itself
  assign bus_reference_clock = bus_clk & refen_r;
  assign separate_address_lines = adr_r;
  assign shared_addr_data_o = ad_o_r;
  assign shared_addr_data_oe = ad_oe_r;
  assign chip_sel_n = cs_n_r;
  assign upper_byte_select_n = ubs_n_r;
  assign addr_latch_en = ale_r;
  assign read_strobe_n = rd_n_r;
  assign write_strobe_n = wr_n_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] ph_cyc_r;
  always_ff @(posedge bus_clk or negedge nrst) begin
    if (!nrst) ph_cyc_r <= '0;
    else ph_cyc_r <= (st_nxt != st_r) ? 8'h00 : ph_cyc_r + 8'h01;
  end
  wire [7:0] ph_cyc_n = ph_cyc_r + 8'h01;
  sequence rdy_wait_s;
    (st_r == ebs_pkg::EBS_RDY) && (sub_r == '0) && !rdy_act;
  endsequence

  ab_len_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    (st_r == ebs_pkg::EBS_AB && st_nxt != st_r) |-> ph_cyc_n == la_r * ebs_pkg::TCS_CYC)
    else $error("address setup length wrong");
  c_len_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    (st_r == ebs_pkg::EBS_C && st_nxt != st_r) |-> ph_cyc_n == lc_r * ebs_pkg::TCS_CYC)
    else $error("command delay length wrong");
  e_len_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    (st_r == ebs_pkg::EBS_E && st_nxt != st_r) |-> ph_cyc_n == le_r * ebs_pkg::TCS_CYC)
    else $error("access length wrong");
  f_len_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    (st_r == ebs_pkg::EBS_F && st_nxt != st_r) |-> ph_cyc_n == lf_r * ebs_pkg::TCS_CYC)
    else $error("hold length wrong");
  skip_zero_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    (st_r == ebs_pkg::EBS_AB) ##1 (st_r != ebs_pkg::EBS_AB && st_r != ebs_pkg::EBS_C)
    |-> $past(lc_r) == '0)
    else $error("command delay not skipped correctly");
  strobe_win_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    !rd_n_r || !wr_n_r |-> (st_r == ebs_pkg::EBS_E || st_r == ebs_pkg::EBS_RDY))
    else $error("strobe outside access phase");
  rdy_wait_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    rdy_wait_s |=> (st_r == ebs_pkg::EBS_RDY) && !(rd_n_r && wr_n_r))
    else $error("waitstate not inserted");
  rdy_end_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    (st_r == ebs_pkg::EBS_RDY && sub_r == '0 && rdy_act)
    |=> st_r == ebs_pkg::EBS_F || st_r == ebs_pkg::EBS_IDLE)
    else $error("ready did not end cycle");
  new_cycle_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    $rose(st_r == ebs_pkg::EBS_AB) |-> $past(st_r) == ebs_pkg::EBS_IDLE && $past(cs_n_r) == '1)
    else $error("cycle started before hold done");
  rd_cap_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    $rose(rd_n_r) |-> rdata_b_r == $past(shared_addr_data_i))
    else $error("read data not captured at strobe end");
  mux_addr_a: assert property (@(posedge bus_clk) disable iff (!nrst)
    addr_latch_en |-> ad_oe_r && ad_o_r == adr_r[ebs_pkg::DATA_W-1:0])
    else $error("multiplexed address missing");
endmodule

// ---- verif/ebs_mem_model.sv ----
// Behavioural external memory standing on the parallel bus.
// Assumes the bench resolves the shared lines and feeds the wire back in.
module ebs_mem_model (
  input wire logic bus_clk, // Bus clock
  input wire logic mux, // 1 multiplexed bus
  input wire logic ale, // Address latch enable
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic [23:0] addr, // Separate address lines
  input wire logic [15:0] ad, // Resolved shared lines
  input wire logic [5:0] wait_n, // Units before ready
  input wire logic pol, // Ready active level
  output logic [15:0] drv, // Value offered on shared lines
  output logic ready // Ready handshake
);
  logic [15:0] mem [16];
  logic [3:0] lat;
  logic [5:0] cnt;
  logic [15:0] last;
  wire [3:0] idx = mux ? lat : addr[3:0];
  always_ff @(posedge bus_clk) begin
    if (ale) lat <= ad[3:0];
    if (!wr_n) mem[idx] <= ad;
    cnt <= (rd_n && wr_n) ? 6'h00 : cnt + 6'h01;
    if (!rd_n) last <= mem[idx];
  end
  // Released lines show the inverse of the last word, so a late capture cannot pass
  assign drv = !rd_n ? mem[idx] : ~last;
  assign ready = (cnt >= wait_n) ? pol : !pol;
endmodule

// ---- verif/tb_external_bus_cycle_sequencer.sv ----
// Self-checking bench for the bus cycle sequencer with a memory model.
// Assumes config words change only while the sequencer is idle.
module tb_external_bus_cycle_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, bus_clk = 0, nrst = 0, req_valid = 0, req_write = 0, mux_mode = 1;
  logic ref_clk_en = 0, rdy_pol = 0, req_ready, rsp_valid, busy, bus_reference_clock;
  logic [1:0] req_cs = 0, req_be = 2'h3, last_cs = 0;
  logic [23:0] req_addr = 0, sep_addr;
  logic [15:0] req_wdata = 0, rsp_rdata, ad_o, drv, ale_ad;
  logic [63:0] cfg = 0;
  logic [5:0] rdy_wait = 0;
  logic [3:0] cs_n, cs_seen;
  logic ad_oe, ubs_n, ale, rd_n, wr_n, ready_pin, cs_prev = 1, ubs_seen;
  int mismatches = 0, checked = 0, cyc = 0, cs_cyc, stb_cyc, starts, refused, rsp_cnt;
  wire [15:0] ad = ad_oe ? ad_o : drv;
  initial forever #2.5 mclk = ~mclk;
  initial begin
    #3;
    forever #40 bus_clk = ~bus_clk;
  end
  ebs_seq dut (.mclk(mclk), .nrst(nrst), .bus_clk(bus_clk), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_cs(req_cs), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .busy(busy), .chip_select_timing_config(cfg), .mux_mode(mux_mode),
    .ref_clk_en(ref_clk_en), .bus_reference_clock(bus_reference_clock),
    .separate_address_lines(sep_addr), .shared_addr_data_o(ad_o), .shared_addr_data_i(ad),
    .shared_addr_data_oe(ad_oe), .chip_sel_n(cs_n), .upper_byte_select_n(ubs_n),
    .addr_latch_en(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .ready_pin(ready_pin));
  ebs_mem_model mem (.bus_clk(bus_clk), .mux(mux_mode), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .addr(sep_addr), .ad(ad), .wait_n(rdy_wait), .pol(rdy_pol), .drv(drv), .ready(ready_pin));
  // ----------------------------------------------------------------
  // Pin monitors
  // ----------------------------------------------------------------
  always @(negedge bus_clk) begin
    if (!(&cs_n)) cs_cyc++;
    if (!rd_n || !wr_n) stb_cyc++;
    if (cs_prev && !(&cs_n)) starts++;
    if (ale) ale_ad = ad;
    if (!(&cs_n)) {cs_seen, ubs_seen} = {cs_n, ubs_n};
    cs_prev = &cs_n;
  end
  always @(posedge mclk) begin
    if (req_valid && !req_ready) refused++;
    if (rsp_valid) rsp_cnt++;
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      test_done;
    end
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send(input logic w, input logic [23:0] a, input logic [15:0] d);
    @(negedge mclk);
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    do @(posedge mclk); while (req_ready !== 1'b1);
  endtask
  task automatic get_rsp(input int k);
    @(negedge mclk);
    req_valid = 0;
    for (int i = 0; i < 4000 && rsp_cnt < k; i++) @(posedge mclk);
    check(rsp_cnt, k);
  endtask
  function automatic logic [15:0] mk(input logic [7:0] t, input logic [4:0] em1);
    mk = {t[7:5], t[4:3], em1, t[2], t[1:0], 2'h0, 1'b0} | {13'h0, t[7:6] == 2'h0, 2'h0};
  endfunction
  task automatic run(input logic w, input logic [1:0] cs, input logic [23:0] a,
                     input logic [15:0] d, input logic [15:0] cw);
    int len;
    @(negedge mclk);
    len = 2 + cw[0] + ((cs != last_cs) ? cw[2:1] : 0) + cw[4:3] + cw[5] + cw[10:6] + cw[12:11];
    cfg[cs*16 +: 16] = cw;
    req_cs = cs;
    last_cs = cs;
    cs_cyc = 0;
    stb_cyc = 0;
    rsp_cnt = 0;
    send(w, a, d);
    get_rsp(1);
    if (!cw[13]) check(cs_cyc, len);
    if (!cw[13]) check(stb_cyc, cw[10:6] + 1);
    check(cs_seen, 4'hF ^ (4'h1 << cs));
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    nrst = 1;
    run(1, 0, 24'h000005, 16'hA5C3, 16'h0000);
    check(ale_ad, 16'h0005);
    check(ubs_seen, 0);
    run(0, 0, 24'h000005, 16'h0000, 16'h0000);
    check(rsp_rdata, 16'hA5C3);
    $display("test 1 done");
    @(negedge mclk);
    mux_mode = 0;
    req_be = 2'h1;
    run(1, 1, 24'h123456, 16'h3C5A, 16'h1FFF);
    check(ubs_seen, 1);
    run(0, 1, 24'h123456, 16'h0000, 16'h1FFF);
    check(rsp_rdata, 16'h3C5A);
    $display("test 2 done");
    for (int p = 0; p < 2; p++) begin
      rdy_pol = p[0];
      rdy_wait = 6'h04;
      run(0, 2 + p, 24'h000005, 16'h0000, {!p[0], p[0], 1'b1, 13'h0000});
      check(rsp_rdata, 16'hA5C3);
      check(stb_cyc > 4, 1);
    end
    $display("test 3 done");
    @(negedge mclk);
    mux_mode = 1;
    req_be = 2'h3;
    cfg[15:0] = 16'h0000;
    req_cs = 0;
    cs_cyc = 0;
    starts = 0;
    refused = 0;
    rsp_cnt = 0;
    for (int i = 0; i < 4; i++) send(1, 24'h000008 + i, 16'h1200 + i);
    get_rsp(4);
    check(starts, 4);
    check(cs_cyc, 8);
    check(refused > 0, 1);
    check(busy, 0);
    $display("test 4 done");
    @(posedge bus_clk);
    #20 check(bus_reference_clock, 0);
    @(negedge mclk);
    ref_clk_en = 1;
    repeat (4) @(posedge bus_clk);
    #20 check(bus_reference_clock, 1);
    @(negedge bus_clk);
    #20 check(bus_reference_clock, 0);
    $display("test 5 done");
    test_done;
  end
endmodule
